//--- logic/acpm_pkg.sv
// Shared constants, level codes and decoding for the converter control pins
//
// Summary of operation
// R01 - Extended mode: swing pin is serial clock
// R02 - Normal mode: edge pin picks data edge
// R03 - Normal mode: edge pin mid/floating selects double data rate
// R04 - Extended mode: edge pin is serial data
// R05 - Resync pulse resets output clock divider
// R06 - Full powerdown high stops whole converter
// R07 - Q powerdown high stops only Q channel
// R08 - Trigger low then high starts calibration
// R09 - Normal mode: range pin low small, high large
// R10 - Range pin mid/floating enters extended mode
// R11 - Range pin driven: delay pin sets power-up delay
// R12 - Range pin floating: delay pin is serial select
// R13 - Extended mode forces short power-up delay
// R14 - Delay pin mid: dual edge I sampling, Q ignored
// R15 - Samples taken at sample clock falling edge; the sample strobes here are registered on the clk_sys rising edge
// R16 - Calibration flag high while calibration runs
// R17 - Output clock half rate SDR, quarter DDR
// R18 - Output clock held still during calibration
// R19 - Three-level pins decode low, high, mid
// R20 - Serial pins ignored unless selected in extended mode
package acpm_pkg;

    // ****************************************
    // Pin level codes
    // ****************************************
    typedef enum logic [1:0] {
        ACPM_LVL_LOW  = 2'h0,
        ACPM_LVL_HIGH = 2'h1,
        ACPM_LVL_MID  = 2'h2
    } acpm_level_t;

    // ****************************************
    // Cycle counts, widths and divider reset value
    // ****************************************
    localparam int CAL_LOW_MIN_CYC   = 80;
    localparam int CAL_HIGH_MIN_CYC  = 80;
    localparam int CAL_RUN_CYC       = 1400;
    localparam int PWRUP_SHORT_CYC   = 8192;
    localparam int PWRUP_LONG_CYC    = 65536;
    localparam int CFG_WORD_BITS     = 24;
    localparam int CNT_W             = 32;
    localparam logic [1:0] DIV_RESET = 2'h0;

    // ****************************************
    // Three-level decode
    // ****************************************
    function automatic acpm_level_t acpm_decode(input logic [1:0] pin);
        acpm_level_t lvl;
        lvl = ACPM_LVL_MID;
        if (pin == 2'h0) begin
            lvl = ACPM_LVL_LOW;
        end else if (pin == 2'h1) begin
            lvl = ACPM_LVL_HIGH;
        end
        return lvl;
    endfunction

endpackage

//--- logic/acpm_pins_if.sv
// Control pins between host controller and converter
`timescale 1ns/10ps
interface acpm_pins_if;
    logic [1:0] output_swing_select;
    logic [1:0] output_edge_select;
    logic [1:0] input_range_select;
    logic [1:0] calibration_start_delay;
    logic       output_clock_resync;
    logic       full_powerdown;
    logic       q_channel_powerdown;
    logic       cal_trigger;
    logic       output_data_clock;
    logic       calibration_active_flag;

    modport dev (
        input  output_swing_select,
        input  output_edge_select,
        input  input_range_select,
        input  calibration_start_delay,
        input  output_clock_resync,
        input  full_powerdown,
        input  q_channel_powerdown,
        input  cal_trigger,
        output output_data_clock,
        output calibration_active_flag
    );

    modport host (
        output output_swing_select,
        output output_edge_select,
        output input_range_select,
        output calibration_start_delay,
        output output_clock_resync,
        output full_powerdown,
        output q_channel_powerdown,
        output cal_trigger,
        input  output_data_clock,
        input  calibration_active_flag
    );
endinterface

//--- logic/acpm_device.sv
// Converter end: pin mode decode, serial capture, output clock and calibration
`timescale 1ns/10ps
module acpm_device #(
    parameter int CFG_W       = acpm_pkg::CFG_WORD_BITS,
    parameter int PWRUP_SHORT = acpm_pkg::PWRUP_SHORT_CYC,
    parameter int PWRUP_LONG  = acpm_pkg::PWRUP_LONG_CYC,
    parameter int CAL_LOW     = acpm_pkg::CAL_LOW_MIN_CYC,
    parameter int CAL_HIGH    = acpm_pkg::CAL_HIGH_MIN_CYC,
    parameter int CAL_RUN     = acpm_pkg::CAL_RUN_CYC
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    acpm_pins_if.dev              pins,
    output logic                  ext_mode,
    output logic                  ddr_mode,
    output logic                  edge_rising,
    output logic                  swing_full,
    output logic                  range_large,
    output logic                  des_mode,
    output logic                  conv_powered,
    output logic                  q_powered,
    output logic                  sample_i_take,
    output logic                  sample_i_second,
    output logic                  sample_q_take,
    output logic                  data_launch,
    output logic [CFG_W-1:0]      cfg_word,
    output logic                  cfg_valid
);

    typedef enum logic [3:0] {
        ST_STRAP = 4'h1,
        ST_WAIT  = 4'h2,
        ST_CAL   = 4'h4,
        ST_READY = 4'h8
    } acpm_cal_st_t;

    localparam logic [31:0] SHORT_C = 32'(PWRUP_SHORT);
    localparam logic [31:0] LONG_C  = 32'(PWRUP_LONG);
    localparam logic [31:0] RUN_C   = 32'(CAL_RUN);
    localparam logic [15:0] LOW_C   = 16'(CAL_LOW);
    localparam logic [15:0] HIGH_C  = 16'(CAL_HIGH);
    localparam int          BCNT_W  = $clog2(CFG_W + 1);
    localparam logic [BCNT_W-1:0] LAST_BIT = BCNT_W'(CFG_W - 1);

    // ****************************************
    // Pin decode
    // ****************************************
    acpm_pkg::acpm_level_t range_lvl;
    acpm_pkg::acpm_level_t edge_lvl;
    acpm_pkg::acpm_level_t swing_lvl;
    acpm_pkg::acpm_level_t dly_lvl;
    logic                  ext_now;
    logic                  sel_now;
    logic                  sclk_now;
    logic                  config_serial_input_now;

    assign range_lvl = acpm_pkg::acpm_decode(pins.input_range_select);      // [R19]
    assign edge_lvl  = acpm_pkg::acpm_decode(pins.output_edge_select);      // [R19]
    assign swing_lvl = acpm_pkg::acpm_decode(pins.output_swing_select);     // [R19]
    assign dly_lvl   = acpm_pkg::acpm_decode(pins.calibration_start_delay); // [R19]
    assign ext_now   = (range_lvl == acpm_pkg::ACPM_LVL_MID);               // [R10]
    assign sel_now   = ext_now && (dly_lvl == acpm_pkg::ACPM_LVL_LOW);      // [R12] [R20]
    assign sclk_now  = (swing_lvl == acpm_pkg::ACPM_LVL_HIGH);              // [R01]
    assign config_serial_input_now = (edge_lvl == acpm_pkg::ACPM_LVL_HIGH);               // [R04]

    // ****************************************
    // Static mode outputs
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_mode     <= 1'b0;
            ddr_mode     <= 1'b0;
            edge_rising  <= 1'b0;
            swing_full   <= 1'b0;
            range_large  <= 1'b0;
            des_mode     <= 1'b0;
            conv_powered <= 1'b0;
            q_powered    <= 1'b0;
        end else begin
            ext_mode     <= ext_now;                                          // [R10]
            ddr_mode     <= !ext_now && (edge_lvl == acpm_pkg::ACPM_LVL_MID); // [R03]
            edge_rising  <= !ext_now && (edge_lvl == acpm_pkg::ACPM_LVL_HIGH);// [R02]
            swing_full   <= !ext_now && (swing_lvl == acpm_pkg::ACPM_LVL_HIGH);
            range_large  <= !ext_now && (range_lvl == acpm_pkg::ACPM_LVL_HIGH);// [R09]
            des_mode     <= (dly_lvl == acpm_pkg::ACPM_LVL_MID);               // [R14]
            conv_powered <= !pins.full_powerdown;                              // [R06]
            q_powered    <= !pins.full_powerdown && !pins.q_channel_powerdown; // [R07]
        end
    end

    // ****************************************
    // Sample strobes
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sample_i_take   <= 1'b0;
            sample_i_second <= 1'b0;
            sample_q_take   <= 1'b0;
        end else begin
            sample_i_take   <= !pins.full_powerdown;                           // [R15] [R06]
            sample_i_second <= !pins.full_powerdown
                               && (dly_lvl == acpm_pkg::ACPM_LVL_MID);          // [R14]
            sample_q_take   <= !pins.full_powerdown && !pins.q_channel_powerdown
                               && (dly_lvl != acpm_pkg::ACPM_LVL_MID);          // [R07] [R14]
        end
    end

    // ****************************************
    // Serial configuration capture
    // ****************************************
    logic              sclk_q;
    logic [CFG_W-1:0]  shift_q;
    logic [BCNT_W-1:0] bcnt_q;
    logic              sclk_rise;

    assign sclk_rise = sclk_now && !sclk_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q    <= 1'b1;
            shift_q   <= '0;
            bcnt_q    <= '0;
            cfg_word  <= '0;
            cfg_valid <= 1'b0;
        end else begin
            sclk_q    <= sclk_now;
            cfg_valid <= 1'b0;
            if (!sel_now) begin
                bcnt_q <= '0;                                           // [R20]
            end else if (sclk_rise) begin
                shift_q <= {shift_q[CFG_W-2:0], config_serial_input_now};             // [R01] [R04]
                if (bcnt_q == LAST_BIT) begin
                    bcnt_q    <= '0;
                    cfg_word  <= {shift_q[CFG_W-2:0], config_serial_input_now};
                    cfg_valid <= 1'b1;
                end else begin
                    bcnt_q <= bcnt_q + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Calibration trigger and sequencer
    // ****************************************
    acpm_cal_st_t st_q;
    logic [31:0]  wait_q;
    logic [15:0]  low_q;
    logic [15:0]  high_q;
    logic         trig_fire;

    assign trig_fire = pins.cal_trigger && (low_q >= LOW_C)
                       && (high_q == HIGH_C - 16'h0001);                 // [R08]

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            low_q  <= '0;
            high_q <= '0;
        end else if (!pins.cal_trigger) begin
            high_q <= '0;
            if (low_q != 16'hFFFF) begin
                low_q <= low_q + 16'h0001;
            end
        end else if (low_q >= LOW_C) begin
            if (trig_fire) begin
                low_q  <= '0;
                high_q <= '0;
            end else begin
                high_q <= high_q + 16'h0001;
            end
        end else begin
            low_q <= '0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q   <= ST_STRAP;
            wait_q <= '0;
        end else begin
            case (st_q)
                ST_STRAP: begin
                    st_q <= ST_WAIT;
                    if (!ext_now && dly_lvl == acpm_pkg::ACPM_LVL_HIGH) begin
                        wait_q <= LONG_C;                               // [R11]
                    end else begin
                        wait_q <= SHORT_C;                              // [R11] [R13]
                    end
                end
                ST_WAIT: begin
                    if (wait_q <= 32'h0000_0001) begin
                        st_q   <= ST_CAL;
                        wait_q <= RUN_C;
                    end else begin
                        wait_q <= wait_q - 32'h0000_0001;
                    end
                end
                ST_CAL: begin
                    if (wait_q <= 32'h0000_0001) begin
                        st_q <= ST_READY;
                    end else begin
                        wait_q <= wait_q - 32'h0000_0001;
                    end
                end
                ST_READY: begin
                    if (trig_fire) begin
                        st_q   <= ST_CAL;                               // [R08]
                        wait_q <= RUN_C;
                    end
                end
                default: begin
                    st_q <= ST_STRAP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pins.calibration_active_flag <= 1'b0;
        end else begin
            pins.calibration_active_flag <= (st_q == ST_CAL);           // [R16]
        end
    end

    // ****************************************
    // Output clock divider
    // ****************************************
    logic [1:0] div_q;
    logic       resync_q;
    logic       oclk_next;

    assign oclk_next = ddr_mode ? div_q[1] : div_q[0];                 // [R17]

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            resync_q <= 1'b0;
            div_q    <= acpm_pkg::DIV_RESET;
        end else begin
            resync_q <= pins.output_clock_resync;
            if (pins.output_clock_resync && !resync_q) begin
                div_q <= acpm_pkg::DIV_RESET;                          // [R05]
            end else begin
                div_q <= div_q + 2'h1;                                 // [R17]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pins.output_data_clock <= 1'b0;
            data_launch            <= 1'b0;
        end else if (st_q == ST_CAL || pins.full_powerdown) begin
            pins.output_data_clock <= 1'b0;                            // [R18]
            data_launch            <= 1'b0;
        end else begin
            pins.output_data_clock <= oclk_next;                       // [R17]
            data_launch <= (oclk_next != pins.output_data_clock)
                           && (ddr_mode || (oclk_next == edge_rising)); // [R02] [R03]
        end
    end

endmodule

//--- logic/acpm_host.sv
// Host end: drives the converter control pins, trigger and serial writes
`timescale 1ns/10ps
module acpm_host #(
    parameter int CFG_W    = acpm_pkg::CFG_WORD_BITS,
    parameter int CAL_LOW  = acpm_pkg::CAL_LOW_MIN_CYC,
    parameter int CAL_HIGH = acpm_pkg::CAL_HIGH_MIN_CYC
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    acpm_pins_if.host             pins,
    input  wire logic [1:0]       req_swing,
    input  wire logic [1:0]       req_edge,
    input  wire logic [1:0]       req_range,
    input  wire logic [1:0]       req_delay,
    input  wire logic             req_full_pd,
    input  wire logic             req_q_pd,
    input  wire logic             resync_req,
    input  wire logic             cal_req,
    input  wire logic             wr_req,
    input  wire logic [CFG_W-1:0] wr_word,
    output logic                  busy,
    output logic                  wr_done,
    output logic                  cal_running
);

    typedef enum logic [6:0] {
        HS_IDLE  = 7'h01,
        HS_CLOW  = 7'h02,
        HS_CHIGH = 7'h04,
        HS_SEL   = 7'h08,
        HS_SLOW  = 7'h10,
        HS_SHIGH = 7'h20,
        HS_SEND  = 7'h40
    } acpm_host_st_t;

    localparam logic [15:0] LOW_C  = 16'(CAL_LOW);
    localparam logic [15:0] HIGH_C = 16'(CAL_HIGH);
    localparam int          BCNT_W = $clog2(CFG_W + 1);
    localparam logic [BCNT_W-1:0] LAST_BIT = BCNT_W'(CFG_W - 1);

    // ****************************************
    // Sequencer
    // ****************************************
    acpm_host_st_t     st_q;
    logic [15:0]       cnt_q;
    logic [CFG_W-1:0]  sh_q;
    logic [BCNT_W-1:0] bit_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q    <= HS_IDLE;
            cnt_q   <= '0;
            sh_q    <= '0;
            bit_q   <= '0;
            wr_done <= 1'b0;
        end else begin
            wr_done <= 1'b0;
            case (st_q)
                HS_IDLE: begin
                    cnt_q <= '0;
                    bit_q <= '0;
                    if (cal_req) begin
                        st_q <= HS_CLOW;
                    end else if (wr_req && req_range == 2'h2) begin
                        st_q <= HS_SEL;
                        sh_q <= wr_word;
                    end
                end
                HS_CLOW: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == LOW_C - 16'h0001) begin
                        st_q  <= HS_CHIGH;                             // [R08]
                        cnt_q <= '0;
                    end
                end
                HS_CHIGH: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == HIGH_C - 16'h0001) begin
                        st_q <= HS_IDLE;                               // [R08]
                    end
                end
                HS_SEL: begin
                    st_q <= HS_SLOW;
                end
                HS_SLOW: begin
                    st_q <= HS_SHIGH;
                end
                HS_SHIGH: begin
                    sh_q <= {sh_q[CFG_W-2:0], 1'b0};
                    if (bit_q == LAST_BIT) begin
                        st_q <= HS_SEND;
                    end else begin
                        bit_q <= bit_q + 1'b1;
                        st_q  <= HS_SLOW;
                    end
                end
                HS_SEND: begin
                    st_q    <= HS_IDLE;
                    wr_done <= 1'b1;
                end
                default: begin
                    st_q <= HS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    logic serial_on;

    assign serial_on = (st_q == HS_SLOW) || (st_q == HS_SHIGH) || (st_q == HS_SEL)
                       || (st_q == HS_SEND);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pins.output_swing_select     <= 2'h1;
            pins.output_edge_select      <= 2'h0;
            pins.input_range_select      <= 2'h0;
            pins.calibration_start_delay <= 2'h0;
            pins.full_powerdown          <= 1'b0;
            pins.q_channel_powerdown     <= 1'b0;
            pins.cal_trigger             <= 1'b0;
            pins.output_clock_resync     <= 1'b0;
        end else begin
            pins.input_range_select  <= req_range;                     // [R10]
            pins.full_powerdown      <= req_full_pd;                   // [R06]
            pins.q_channel_powerdown <= req_q_pd;                      // [R07]
            pins.cal_trigger         <= (st_q == HS_CHIGH);            // [R08]
            pins.output_clock_resync <= resync_req;                    // [R05]
            if (serial_on) begin
                pins.calibration_start_delay <= 2'h0;                  // [R12]
                pins.output_swing_select <= (st_q == HS_SHIGH) ? 2'h1 : 2'h0; // [R01]
                pins.output_edge_select  <= {1'b0, sh_q[CFG_W-1]};     // [R04]
            end else begin
                pins.calibration_start_delay <= req_delay;
                pins.output_swing_select     <= req_swing;
                pins.output_edge_select      <= req_edge;              // [R03]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy        <= 1'b0;
            cal_running <= 1'b0;
        end else begin
            busy        <= (st_q != HS_IDLE) || cal_req || wr_req;
            cal_running <= pins.calibration_active_flag;               // [R16]
        end
    end

endmodule

//--- testbench/acpm_pins_assertions.sv
// Checker for the control pins between host and converter
`timescale 1ns/10ps
module acpm_pins_assertions #(
    parameter int CAL_LOW  = 4,
    parameter int CAL_HIGH = 4,
    parameter int CAL_RUN  = 10
) (
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic [1:0] output_edge_select,
    input wire logic [1:0] input_range_select,
    input wire logic       output_clock_resync,
    input wire logic       full_powerdown,
    input wire logic       cal_trigger,
    input wire logic       output_data_clock,
    input wire logic       calibration_active_flag
);
    logic        run;
    logic        ddr;
    logic        trig_q;
    logic [15:0] lvl_q;
    logic [15:0] cal_q;

    // ****************************************
    // Helper counters
    // ****************************************
    assign run = !full_powerdown && !calibration_active_flag && !output_clock_resync;
    assign ddr = input_range_select < 2'h2 && output_edge_select >= 2'h2;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trig_q <= 1'b0;
            lvl_q  <= 16'h0;
            cal_q  <= 16'h0;
        end else begin
            trig_q <= cal_trigger;
            lvl_q  <= (cal_trigger != trig_q) ? 16'h1 : lvl_q + 16'h1;
            cal_q  <= calibration_active_flag ? cal_q + 16'h1 : 16'h0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    trig_low_a: assert property (cal_trigger && !trig_q |-> lvl_q >= CAL_LOW)
        else $error("trigger low phase too short");
    trig_high_a: assert property (!cal_trigger && trig_q |-> lvl_q >= CAL_HIGH)
        else $error("trigger high phase too short");
    cal_len_a: assert property ($fell(calibration_active_flag) |-> cal_q == CAL_RUN)
        else $error("calibration flag length wrong");
    cal_clk_a: assert property (calibration_active_flag && $past(calibration_active_flag)
        |-> !output_data_clock) else $error("output clock runs in calibration");
    pd_clk_a: assert property (full_powerdown [*2] |=> !output_data_clock)
        else $error("output clock runs in powerdown");
    sdr_clk_a: assert property ((run && !ddr) [*4] |->
        output_data_clock != $past(output_data_clock)) else $error("sdr clock rate wrong");
    ddr_clk_a: assert property ((run && ddr) [*6] |->
        output_data_clock == !$past(output_data_clock, 2)) else $error("ddr clock rate wrong");
    resync_clk_a: assert property ($rose(output_clock_resync) |-> ##[1:3] !output_data_clock)
        else $error("resync did not clear output clock");
endmodule

//--- testbench/adc_pin_mode_control_tb.sv
// Testbench joining host and converter ends over the control pins
`timescale 1ns/10ps
module adc_pin_mode_control_tb;
    localparam int PS = 8;
    localparam int PL = 16;
    localparam int CL = 4;
    localparam int CH = 4;
    localparam int CR = 10;
    logic        clk_sys = 1'b0, rst_n = 1'b0, dev_rst_n = 1'b0;
    logic [1:0]  sw = 2'h1, ed = 2'h0, rg = 2'h0, dl = 2'h0;
    logic        pd = 1'b0, qpd = 1'b0, rs = 1'b0, cal = 1'b0, wr = 1'b0;
    logic [23:0] word = 24'h0, cw;
    logic        ext, ddr, er, sf, rl, des, cp, qp, sq, si2, wd, crun, si, cv, bz;
    int          err_count = 0, n_tests = 0, t0, t1, t2, nv = 0;
    logic [31:0] x = 32'hD59016F4;

    always #2.5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) nv += int'(cv === 1'b1);

    acpm_pins_if pins ();
    acpm_host #(.CAL_LOW(CL), .CAL_HIGH(CH)) i_acpm_host (
        .clk_sys(clk_sys), .arst_n(rst_n), .pins(pins), .req_swing(sw), .req_edge(ed),
        .req_range(rg), .req_delay(dl), .req_full_pd(pd), .req_q_pd(qpd), .resync_req(rs),
        .cal_req(cal), .wr_req(wr), .wr_word(word), .busy(bz), .wr_done(wd), .cal_running(crun));
    acpm_device #(.PWRUP_SHORT(PS), .PWRUP_LONG(PL), .CAL_LOW(CL), .CAL_HIGH(CH),
        .CAL_RUN(CR)) i_acpm_device (
        .clk_sys(clk_sys), .arst_n(dev_rst_n), .pins(pins), .ext_mode(ext), .ddr_mode(ddr),
        .edge_rising(er), .swing_full(sf), .range_large(rl), .des_mode(des), .conv_powered(cp),
        .q_powered(qp), .sample_i_take(si), .sample_i_second(si2), .sample_q_take(sq),
        .data_launch(), .cfg_word(cw), .cfg_valid(cv));
    acpm_pins_assertions #(.CAL_LOW(CL), .CAL_HIGH(CH), .CAL_RUN(CR)) i_acpm_pins_assertions (
        .clk_sys(clk_sys), .arst_n(dev_rst_n), .output_edge_select(pins.output_edge_select),
        .input_range_select(pins.input_range_select),
        .output_clock_resync(pins.output_clock_resync), .full_powerdown(pins.full_powerdown),
        .cal_trigger(pins.cal_trigger), .output_data_clock(pins.output_data_clock),
        .calibration_active_flag(pins.calibration_active_flag));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic final_report();
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wt(int k, logic v, output int t);
        t = 0;
        while ((k ? wd : pins.calibration_active_flag) !== v) begin
            cyc(1);
            t++;
            if (t > 300) begin
                chk("wait", 24'h0, 24'h1);
                final_report();
            end
        end
    endtask

    task automatic pwr(logic [1:0] r, logic [1:0] d, output int t);
        int u;
        rg = r;
        dl = d;
        cyc(3);
        dev_rst_n = 1'b0;
        cyc(4);
        dev_rst_n = 1'b1;
        wt(0, 1'b1, t);
        wt(0, 1'b0, u);
        chk("cal_len", 24'd10, u);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        cyc(4);
        rst_n = 1'b1;
        dev_rst_n = 1'b1;
        pwr(2'h0, 2'h0, t0);
        pwr(2'h0, 2'h1, t1);
        chk("long_delay", PL - PS, t1 - t0);
        pwr(2'h2, 2'h1, t2);
        chk("ext_delay", t0, t2);
        repeat (2) begin
            void'(rnd());
            word = x[23:0];
            wr = 1'b1;
            cyc(1);
            wr = 1'b0;
            chk("busy", 24'h1, bz);
            wt(1, 1'b1, t0);
            cyc(2);
            chk("cfg_word", word, cw);
        end
        chk("cfg_valid", 24'd2, nv);
        for (int j = 0; j < 2; j++) begin
            rg = j ? 2'h2 : 2'h0;
            dl = j ? 2'h1 : 2'h0;
            for (int i = 0; i < 50; i++) begin
                void'(rnd());
                sw = 2'(i % 2);
                ed = {1'b0, x[0]};
                cyc(2);
            end
            chk("cfg_hold", word, cw);
        end
        cal = 1'b1;
        cyc(1);
        cal = 1'b0;
        wt(0, 1'b1, t0);
        cyc(2);
        chk("cal_running", 24'h1, crun);
        wt(0, 1'b0, t0);
        chk("cal_time", 24'd10, t0 + 2);
        for (int i = 0; i < 60; i++) begin
            void'(rnd());
            {sw, ed, rg, dl, pd, qpd, rs} = x[10:0];
            cyc(8);
            chk("ext", rg[1], ext);
            chk("ddr", !rg[1] && ed[1], ddr);
            chk("edge", !rg[1] && ed == 2'h1, er);
            chk("swing", !rg[1] && sw == 2'h1, sf);
            chk("range", !rg[1] && rg == 2'h1, rl);
            chk("des", dl[1], des);
            chk("conv_pwr", !pd, cp);
            chk("q_pwr", !pd && !qpd, qp);
            chk("q_take", !pd && !qpd && !dl[1], sq);
            chk("i_second", !pd && dl[1], si2);
            chk("i_take", !pd, si);
        end
        final_report();
    end
endmodule
